// File: hdl/tmr_consts.vh
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// ==========================================================================
// Register byte addresses.
`define TMR_ADDR_CTRL1      8'h00
`define TMR_ADDR_CTRL2      8'h04
`define TMR_ADDR_STATUS     8'h08
`define TMR_ADDR_CAP1       8'h0C
`define TMR_ADDR_CAP2       8'h10
`define TMR_ADDR_CMP1       8'h14
`define TMR_ADDR_CMP2       8'h18
`define TMR_ADDR_COUNT      8'h1C
`define TMR_ADDR_ALTCOUNT   8'h20
`define TMR_ADDR_POWER      8'h24

// ==========================================================================
// Field positions of control_reg_one.
`define TMR_C1_CAP_IE       7
`define TMR_C1_CMP_IE       6
`define TMR_C1_OVF_IE       5
`define TMR_C1_FORCE2       4
`define TMR_C1_FORCE1       3
`define TMR_C1_LVL_DURING   2
`define TMR_C1_EDGE1        1
`define TMR_C1_LVL_AFTER    0

// ==========================================================================
// Field positions of control_reg_two.
`define TMR_C2_PIN1_EN      7
`define TMR_C2_PIN2_EN      6
`define TMR_C2_PULSE        5
`define TMR_C2_PWM          4
`define TMR_C2_CLK_HI       3
`define TMR_C2_CLK_LO       2
`define TMR_C2_EDGE2        1

// ==========================================================================
// Flag vector positions; the status byte holds the flags in bits 7 to 3.
`define TMR_F_CAP1          4
`define TMR_F_CMP1          3
`define TMR_F_OVF           2
`define TMR_F_CAP2          1
`define TMR_F_CMP2          0

// ==========================================================================
// Field positions of the power register.
`define TMR_P_HALT          0
`define TMR_P_WAIT          1
`define TMR_P_IMASK         2

// ==========================================================================
// Clock select codes and divider end counts.
`define TMR_CLK_DIV4        2'h0
`define TMR_CLK_DIV2        2'h1
`define TMR_CLK_DIV8        2'h2
`define TMR_CLK_SLOW        2'h3
`define TMR_END_DIV2        3'h1
`define TMR_END_DIV4        3'h3
`define TMR_END_DIV8        3'h7
`define TMR_SLOW_DIV        8000

// ==========================================================================
// Counter and capture values.
`define TMR_CNT_RESET       8'hFC
`define TMR_CNT_RELOAD      8'hFC
`define TMR_CNT_TOP         8'hFF
`define TMR_CAP1_PULSE      8'hFD
`define TMR_BYTE_ZERO       8'h00
`define TMR_BYTE_ONE        8'h01

`endif

// File: hdl/tmr_prescaler.v
`timescale 1ns/1ps
`include "tmr_consts.vh"

// ==========================================================================
// Timer clock prescaler: one-cycle tick at the selected rate.
module tmr_prescaler #(
	parameter SLOW_DIV = `TMR_SLOW_DIV
)(
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        run,
	input  wire [1:0]  clock_select,
	input  wire        osc2_clk_pin,
	output reg         tick_q
);

	reg  [2:0]  div_q;
	reg  [12:0] slow_q;
	reg         s1_q;
	reg         s2_q;
	reg         s3_q;
	reg         slow_lvl_q;
	reg  [2:0]  div_end;
	wire        slow_rise;

	// ======================================================================
	// Fast divider end count.
	always @*
	begin
		case (clock_select)
			`TMR_CLK_DIV2: div_end = `TMR_END_DIV2;
			`TMR_CLK_DIV8: div_end = `TMR_END_DIV8;
			default:       div_end = `TMR_END_DIV4;
		endcase
	end

	// A rising slow edge counts once the second and third stages agree high.
	assign slow_rise = (s2_q == s3_q) && s3_q && !slow_lvl_q;

	// ======================================================================
	// Dividers; both hold while the timer is halted.
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			div_q      <= 3'h0;
			slow_q     <= 13'h0000;
			s1_q       <= 1'b0;
			s2_q       <= 1'b0;
			s3_q       <= 1'b0;
			slow_lvl_q <= 1'b0;
			tick_q     <= 1'b0;
		end
		else
		begin
			s1_q   <= osc2_clk_pin;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			tick_q <= 1'b0;
			if (s2_q == s3_q)
				slow_lvl_q <= s3_q;
			if (run)
			begin
				if (clock_select == `TMR_CLK_SLOW)
				begin
					if (slow_rise)
					begin
						if (slow_q >= SLOW_DIV[12:0] - 13'h0001)
						begin
							slow_q <= 13'h0000;
							tick_q <= 1'b1;
						end
						else
							slow_q <= slow_q + 13'h0001;
					end
				end
				else if (div_q >= div_end)
				begin
					div_q  <= 3'h0;
					tick_q <= 1'b1;
				end
				else
					div_q <= div_q + 3'h1;
			end
		end
	end

endmodule

// File: hdl/tmr_timer8.v
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tmr_consts.vh"

// Contract
// - Pin enable clear: no pin drive on match, compare interrupt still possible.
// - At divide-by-2, flag and pin act when counter equals compare value.
// - At other rates, flag and pin act when counter equals compare plus one.
// - Force bit copies level bit to enabled pin, no flag, no interrupt.
// - Force bits do nothing in single-pulse or pulse-width mode.
// - Single-pulse mode uses capture 1 as trigger, compare 1 as generator.
// - Pulse trigger: counter FCh, pin takes during-level, capture flag 1, capture1 FDh.
// - Single-pulse compare 1 match drives after-level, ending the pulse.
// - Single-pulse: compare flag 1 never set; compare flag 2 still set.
// - Single-pulse: compare 2 times only, makes no waveform.
// - Single-pulse: capture 1 does not capture; capture 2 does; trigger resets count.
// - Both mode bits set: only pulse-width mode operates.
// - Equal level bits give a constant compare pin 1 level.
// - Pulse-width compare writes are buffered until the period ends.
// - Pulse-width: compare 2 reloads FCh, during-level; compare 1 gives after-level.
// - Pulse-width mode never sets compare flags.
// - Pulse-width: compare 2 match sets capture flag 1, interrupt if enabled.
// - Pulse-width: capture 1 disconnected, capture 2 still captures.
// - Wait mode leaves timer running; enabled interrupt ends wait.
// - Halt stops counter; interrupt wake resumes, reset wake restarts.
// - Halt capture edge arms; interrupt wake sets flag and captures count.
// - Compare interrupt enable covers both compare flags.
// - Clock select: 00 /4, 01 /2, 10 /8, 11 slow clock /8000.
// - Counter rolls FFh to 00h and sets overflow flag, except when a pulse-width compare 2 reload falls at FFh.
module tmr_timer8 #(
	parameter SLOW_DIV = `TMR_SLOW_DIV
)(
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata_q,
	output reg         hreadyout_q,
	output reg         hresp_q,
	input  wire        capture1_input_pin,
	input  wire        capture2_input_pin,
	input  wire        osc2_clk_pin,
	output reg         compare1_output_pin_q,
	output reg         compare2_output_pin_q,
	output wire        compare1_pin_enable,
	output wire        compare2_pin_enable,
	output reg         timer_irq_q
);

	// ======================================================================
	// State.
	reg  [7:0]  control_reg_one_q;
	reg  [7:0]  control_reg_two_q;
	reg  [7:0]  compare1_value_q;
	reg  [7:0]  compare2_value_q;
	reg  [7:0]  cmp1_act_q;
	reg  [7:0]  cmp2_act_q;
	reg  [7:0]  capture1_value_q;
	reg  [7:0]  capture2_value_q;
	reg  [7:0]  cnt_q;
	reg  [4:0]  flags_q;
	reg  [4:0]  clr_arm_q;
	reg  [2:0]  power_q;
	reg  [1:0]  halt_arm_q;
	reg         wr_pend_q;
	reg  [7:0]  wr_addr_q;
	reg  [1:0]  cap_s1_q;
	reg  [1:0]  cap_s2_q;
	reg  [1:0]  cap_s3_q;
	reg  [1:0]  cap_lvl_q;

	wire        tick;
	wire        pwm_on;
	wire        pulse_on;
	wire        halted;
	wire [1:0]  clk_sel;
	wire [7:0]  tgt1;
	wire [7:0]  tgt2;
	wire [7:0]  cnt_inc;
	wire        m1;
	wire        m2;
	wire [1:0]  cap_edge;
	wire        cap1_ev;
	wire        cap2_ev;
	wire        pulse_trig;
	wire        halt_exit;
	wire        rd_acc;
	wire [7:0]  rd_addr;
	wire        wr_acc;
	wire        ctrl1_wr;
	wire [4:0]  clr;
	wire [4:0]  set;
	wire        irq_d;
	wire        ovf;
	wire        pwm_reload;
	reg  [7:0]  rd_data;

	// ======================================================================
	// Functions.
	function [7:0] match_target;
		input [7:0] value;
		input [1:0] sel;
		begin
			if (sel == `TMR_CLK_DIV2)
				match_target = value;
			else
				match_target = value + `TMR_BYTE_ONE;
		end
	endfunction

	function edge_ok;
		input s2;
		input s3;
		input lvl;
		input rising;
		begin
			edge_ok = (s2 == s3) && (s3 != lvl) && (s3 == rising);
		end
	endfunction

	function is_access;
		input [7:0] reg_addr;
		input       rd;
		input [7:0] raddr;
		input       wr;
		input [7:0] waddr;
		begin
			is_access = (rd && raddr == reg_addr) || (wr && waddr == reg_addr);
		end
	endfunction

	// ======================================================================
	// Prescaler; halted counter gets no ticks.
	tmr_prescaler #(
		.SLOW_DIV     (SLOW_DIV)
	) u_presc (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.run          (!halted),
		.clock_select (clk_sel),
		.osc2_clk_pin (osc2_clk_pin),
		.tick_q       (tick)
	);

	// ======================================================================
	// Mode decode and compare matches.
	assign clk_sel  = control_reg_two_q[`TMR_C2_CLK_HI:`TMR_C2_CLK_LO];
	assign pwm_on   = control_reg_two_q[`TMR_C2_PWM];
	assign pulse_on = control_reg_two_q[`TMR_C2_PULSE] && !pwm_on;
	assign halted   = power_q[`TMR_P_HALT];
	assign tgt1     = match_target(cmp1_act_q, clk_sel);
	assign tgt2     = match_target(cmp2_act_q, clk_sel);
	assign cnt_inc  = cnt_q + `TMR_BYTE_ONE;
	assign m1       = tick && (cnt_inc == tgt1);
	assign m2       = tick && (cnt_inc == tgt2);
	assign pwm_reload = pwm_on && m2;
	assign ovf      = tick && (cnt_q == `TMR_CNT_TOP) && !pwm_reload;

	// ======================================================================
	// Capture pin edges.
	assign cap_edge[0] = edge_ok(cap_s2_q[0], cap_s3_q[0], cap_lvl_q[0],
		control_reg_one_q[`TMR_C1_EDGE1]);
	assign cap_edge[1] = edge_ok(cap_s2_q[1], cap_s3_q[1], cap_lvl_q[1],
		control_reg_two_q[`TMR_C2_EDGE2]);
	assign cap1_ev    = cap_edge[0] && !halted && !pwm_on && !pulse_on;
	assign cap2_ev    = cap_edge[1] && !halted;
	assign pulse_trig = cap_edge[0] && !halted && pulse_on;

	// ======================================================================
	// Bus decode.
	assign rd_acc   = hsel && hready && htrans[1] && !hwrite;
	assign rd_addr  = haddr[7:0];
	assign wr_acc   = wr_pend_q;
	assign ctrl1_wr = wr_acc && (wr_addr_q == `TMR_ADDR_CTRL1);
	assign halt_exit = wr_acc && (wr_addr_q == `TMR_ADDR_POWER) && halted &&
		!hwdata[`TMR_P_HALT];

	assign clr[`TMR_F_CAP1] = clr_arm_q[`TMR_F_CAP1] &&
		is_access(`TMR_ADDR_CAP1, rd_acc, rd_addr, wr_acc, wr_addr_q);
	assign clr[`TMR_F_CAP2] = clr_arm_q[`TMR_F_CAP2] &&
		is_access(`TMR_ADDR_CAP2, rd_acc, rd_addr, wr_acc, wr_addr_q);
	assign clr[`TMR_F_CMP1] = clr_arm_q[`TMR_F_CMP1] &&
		is_access(`TMR_ADDR_CMP1, rd_acc, rd_addr, wr_acc, wr_addr_q);
	assign clr[`TMR_F_CMP2] = clr_arm_q[`TMR_F_CMP2] &&
		is_access(`TMR_ADDR_CMP2, rd_acc, rd_addr, wr_acc, wr_addr_q);
	assign clr[`TMR_F_OVF]  = clr_arm_q[`TMR_F_OVF] &&
		is_access(`TMR_ADDR_COUNT, rd_acc, rd_addr, wr_acc, wr_addr_q);

	// ======================================================================
	// Flag events.
	assign set[`TMR_F_CAP1] = cap1_ev || pulse_trig || pwm_reload ||
		(halt_exit && halt_arm_q[0]);
	assign set[`TMR_F_CAP2] = cap2_ev || (halt_exit && halt_arm_q[1]);
	assign set[`TMR_F_CMP1] = m1 && !pwm_on && !pulse_on;
	assign set[`TMR_F_CMP2] = m2 && !pwm_on;
	assign set[`TMR_F_OVF]  = ovf;

	assign irq_d = !power_q[`TMR_P_IMASK] && (
		(control_reg_one_q[`TMR_C1_CAP_IE] &&
			(flags_q[`TMR_F_CAP1] || flags_q[`TMR_F_CAP2])) ||
		(control_reg_one_q[`TMR_C1_CMP_IE] &&
			(flags_q[`TMR_F_CMP1] || flags_q[`TMR_F_CMP2])) ||
		(control_reg_one_q[`TMR_C1_OVF_IE] && flags_q[`TMR_F_OVF]));

	assign compare1_pin_enable = control_reg_two_q[`TMR_C2_PIN1_EN];
	assign compare2_pin_enable = control_reg_two_q[`TMR_C2_PIN2_EN];

	// ======================================================================
	// Read data selection.
	always @*
	begin
		case (rd_addr)
			`TMR_ADDR_CTRL1:    rd_data = control_reg_one_q;
			`TMR_ADDR_CTRL2:    rd_data = {control_reg_two_q[7:1], 1'b0};
			`TMR_ADDR_STATUS:   rd_data = {flags_q, 3'h0};
			`TMR_ADDR_CAP1:     rd_data = capture1_value_q;
			`TMR_ADDR_CAP2:     rd_data = capture2_value_q;
			`TMR_ADDR_CMP1:     rd_data = compare1_value_q;
			`TMR_ADDR_CMP2:     rd_data = compare2_value_q;
			`TMR_ADDR_COUNT:    rd_data = cnt_q;
			`TMR_ADDR_ALTCOUNT: rd_data = cnt_q;
			`TMR_ADDR_POWER:    rd_data = {5'h00, power_q};
			default:            rd_data = `TMR_BYTE_ZERO;
		endcase
	end

	// ======================================================================
	// Bus slave: zero wait states, always OKAY.
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			hrdata_q    <= 32'h00000000;
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= `TMR_BYTE_ZERO;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
			wr_pend_q   <= hsel && hready && htrans[1] && hwrite;
			wr_addr_q   <= haddr[7:0];
			if (rd_acc)
				hrdata_q <= {24'h000000, rd_data};
		end
	end

	// ======================================================================
	// Configuration, power and compare registers.
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			control_reg_one_q <= `TMR_BYTE_ZERO;
			control_reg_two_q <= `TMR_BYTE_ZERO;
			compare1_value_q  <= `TMR_BYTE_ZERO;
			compare2_value_q  <= `TMR_BYTE_ZERO;
			cmp1_act_q        <= `TMR_BYTE_ZERO;
			cmp2_act_q        <= `TMR_BYTE_ZERO;
			power_q           <= 3'h0;
		end
		else
		begin
			if (ctrl1_wr)
				control_reg_one_q <= hwdata[7:0];
			if (wr_acc && wr_addr_q == `TMR_ADDR_CTRL2)
				control_reg_two_q <= {hwdata[7:1], 1'b0};
			if (wr_acc && wr_addr_q == `TMR_ADDR_CMP1)
				compare1_value_q <= hwdata[7:0];
			if (wr_acc && wr_addr_q == `TMR_ADDR_CMP2)
				compare2_value_q <= hwdata[7:0];
			if (!pwm_on || m2)
			begin
				cmp1_act_q <= compare1_value_q;
				cmp2_act_q <= compare2_value_q;
			end
			if (wr_acc && wr_addr_q == `TMR_ADDR_POWER)
				power_q <= hwdata[2:0];
			else if (irq_d)
				power_q[`TMR_P_WAIT] <= 1'b0;
		end
	end

	// ======================================================================
	// Counter, captures, flags and halt arming.
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			cnt_q            <= `TMR_CNT_RESET;
			capture1_value_q <= `TMR_BYTE_ZERO;
			capture2_value_q <= `TMR_BYTE_ZERO;
			flags_q          <= 5'h00;
			clr_arm_q        <= 5'h00;
			halt_arm_q       <= 2'h0;
			cap_s1_q         <= 2'h0;
			cap_s2_q         <= 2'h0;
			cap_s3_q         <= 2'h0;
			cap_lvl_q        <= 2'h0;
			timer_irq_q      <= 1'b0;
		end
		else
		begin
			cap_s1_q <= {capture2_input_pin, capture1_input_pin};
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			if (cap_s2_q[0] == cap_s3_q[0])
				cap_lvl_q[0] <= cap_s3_q[0];
			if (cap_s2_q[1] == cap_s3_q[1])
				cap_lvl_q[1] <= cap_s3_q[1];

			if (pulse_trig)
				cnt_q <= `TMR_CNT_RELOAD;
			else if (pwm_reload)
				cnt_q <= `TMR_CNT_RELOAD;
			else if (tick)
				cnt_q <= cnt_inc;

			if (pulse_trig)
				capture1_value_q <= `TMR_CAP1_PULSE;
			else if (cap1_ev || (halt_exit && halt_arm_q[0]))
				capture1_value_q <= cnt_q;
			if (cap2_ev || (halt_exit && halt_arm_q[1]))
				capture2_value_q <= cnt_q;

			if (!halted || halt_exit)
				halt_arm_q <= 2'h0;
			else
			begin
				if (cap_edge[0] && !pwm_on && !pulse_on)
					halt_arm_q[0] <= 1'b1;
				if (cap_edge[1])
					halt_arm_q[1] <= 1'b1;
			end

			flags_q <= (flags_q & ~clr) | set;
			if (rd_acc && rd_addr == `TMR_ADDR_STATUS)
				clr_arm_q <= flags_q;
			else
				clr_arm_q <= clr_arm_q & ~clr;

			timer_irq_q <= irq_d;
		end
	end

	// ======================================================================
	// Compare output pins.
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			compare1_output_pin_q <= 1'b0;
			compare2_output_pin_q <= 1'b0;
		end
		else if (pwm_on)
		begin
			if (pwm_reload && compare1_pin_enable)
				compare1_output_pin_q <= control_reg_one_q[`TMR_C1_LVL_DURING];
			else if (m1 && compare1_pin_enable)
				compare1_output_pin_q <= control_reg_one_q[`TMR_C1_LVL_AFTER];
		end
		else if (pulse_on)
		begin
			if (pulse_trig && compare1_pin_enable)
				compare1_output_pin_q <= control_reg_one_q[`TMR_C1_LVL_DURING];
			else if (m1 && compare1_pin_enable)
				compare1_output_pin_q <= control_reg_one_q[`TMR_C1_LVL_AFTER];
		end
		else
		begin
			if (ctrl1_wr && hwdata[`TMR_C1_FORCE1] && compare1_pin_enable)
				compare1_output_pin_q <= hwdata[`TMR_C1_LVL_AFTER];
			else if (m1 && compare1_pin_enable)
				compare1_output_pin_q <= control_reg_one_q[`TMR_C1_LVL_AFTER];
			if (ctrl1_wr && hwdata[`TMR_C1_FORCE2] && compare2_pin_enable)
				compare2_output_pin_q <= hwdata[`TMR_C1_LVL_DURING];
			else if (m2 && compare2_pin_enable)
				compare2_output_pin_q <= control_reg_one_q[`TMR_C1_LVL_DURING];
		end
	end

endmodule

// File: test/tmr_timer8_assertions.sv
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks of the timer bus slave and compare pins.
module tmr_timer8_chk #(
	parameter SLOW_DIV = 8000
)(
	input wire        ref_clk,
	input wire        rst_n,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata_q,
	input wire        hreadyout_q,
	input wire        hresp_q,
	input wire        capture1_input_pin,
	input wire        capture2_input_pin,
	input wire        osc2_clk_pin,
	input wire        compare1_output_pin_q,
	input wire        compare2_output_pin_q,
	input wire        compare1_pin_enable,
	input wire        compare2_pin_enable,
	input wire        timer_irq_q
);
	wire              req_w;

	assign req_w = hsel && hready && htrans[1];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	hready_ok_a: assert property (hreadyout_q) else $error("ready low");
	resp_okay_a: assert property (!hresp_q) else $error("error response");
	rdata_upper_a: assert property (hrdata_q[31:8] == 24'h000000) else $error("upper data set");
	reset_vals_a: assert property ($rose(rst_n) |-> !compare1_output_pin_q
		&& !compare2_output_pin_q && !timer_irq_q && hrdata_q == 32'h00000000)
		else $error("bad values after reset");
	unmapped_zero_a: assert property (req_w && !hwrite && haddr[7:0] > 8'h27
		|=> hrdata_q == 32'h00000000) else $error("unmapped read not zero");
	cfg_write_only_a: assert property ($changed(compare1_pin_enable)
		|-> $past(req_w && hwrite && haddr[7:0] == 8'h04, 2)) else $error("enable moved");
	pin1_idle_a: assert property (!compare1_pin_enable ##1 !compare1_pin_enable
		|-> $stable(compare1_output_pin_q)) else $error("pin 1 moved while disabled");
	pin2_idle_a: assert property (!compare2_pin_enable ##1 !compare2_pin_enable
		|-> $stable(compare2_output_pin_q)) else $error("pin 2 moved while disabled");

	cover property ($rose(timer_irq_q));
	cover property ($rose(compare1_output_pin_q));
	cover property ($rose(compare2_output_pin_q));
endmodule

bind tmr_timer8 tmr_timer8_chk #(.SLOW_DIV(SLOW_DIV)) chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
	.capture1_input_pin(capture1_input_pin), .capture2_input_pin(capture2_input_pin),
	.osc2_clk_pin(osc2_clk_pin), .compare1_output_pin_q(compare1_output_pin_q),
	.compare2_output_pin_q(compare2_output_pin_q), .compare1_pin_enable(compare1_pin_enable),
	.compare2_pin_enable(compare2_pin_enable), .timer_irq_q(timer_irq_q)
);

// File: test/tmr_pin_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Far side of the timer pins: capture sources and a free slow oscillator.
module tmr_pin_model (
	input wire ref_clk,
	output reg capture1_input_pin,
	output reg capture2_input_pin,
	output reg osc2_clk_pin
);
	initial
	begin
		capture1_input_pin = 1'b0;
		capture2_input_pin = 1'b0;
		osc2_clk_pin = 1'b0;
	end

	always #35 osc2_clk_pin = ~osc2_clk_pin;

	// Gives a rising then a falling edge on the chosen capture pin.
	task strike(input ch);
		@(posedge ref_clk);
		if (ch)
			capture2_input_pin <= 1'b1;
		else
			capture1_input_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		capture1_input_pin <= 1'b0;
		capture2_input_pin <= 1'b0;
	endtask
endmodule

// File: test/tmr_timer8_tb.sv
`timescale 1ns/1ps
`include "tmr_consts.vh"
// ==========================================================================
// Self-checking bench: rows are {select, divider, compare 1, ticks}.
module tmr_timer8_tb;
	localparam logic [31:0] ROWS [0:3] = '{32'h0102FF03, 32'h0004FF04, 32'h0208FE03,
		32'h0102FE02};
	localparam logic [7:0]  ZADDR [0:8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18,
		8'h24, 8'h30, 8'h7C};
	reg                     ref_clk = 1'b0;
	reg                     rst_n;
	reg                     hsel;
	reg  [31:0]             haddr;
	reg  [1:0]              htrans;
	reg                     hwrite;
	reg  [31:0]             hwdata;
	wire [31:0]             hrdata_q;
	wire                    hreadyout_q;
	wire                    hresp_q;
	wire                    cap1;
	wire                    cap2;
	wire                    osc2;
	wire                    pin1;
	wire                    pin2;
	wire                    en1;
	wire                    en2;
	wire                    irq;
	reg  [31:0]             d;
	reg  [31:0]             c1;
	reg  [31:0]             c2;
	reg  [31:0]             r;
	integer                 n;
	integer                 i;
	integer                 err_total;
	integer                 n_compared;

	always #5 ref_clk = ~ref_clk;

	tmr_timer8 #(.SLOW_DIV(4)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q),
		.hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
		.capture1_input_pin(cap1), .capture2_input_pin(cap2), .osc2_clk_pin(osc2),
		.compare1_output_pin_q(pin1), .compare2_output_pin_q(pin2),
		.compare1_pin_enable(en1), .compare2_pin_enable(en2), .timer_irq_q(irq)
	);
	tmr_pin_model pins_u (
		.ref_clk(ref_clk), .capture1_input_pin(cap1), .capture2_input_pin(cap2),
		.osc2_clk_pin(osc2)
	);

	task tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task check(input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task wait_ready;
		integer k;
		k = 0;
		@(posedge ref_clk);
		while (hreadyout_q !== 1'b1 && k < 50)
		begin
			k = k + 1;
			@(posedge ref_clk);
		end
		check(k < 50, 1'b1);
	endtask

	task xfer(input [7:0] a, input w, input [31:0] wd, output [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata_q;
	endtask

	task wr(input [7:0] a, input [31:0] wd);
		xfer(a, 1'b1, wd, c2);
	endtask

	task rd(input [7:0] a, output [31:0] q);
		xfer(a, 1'b0, 32'h00000000, q);
	endtask

	task wait_sig(input sel, input v, input integer lim, output integer cnt);
		cnt = 0;
		while (((sel ? irq : pin1) !== v) && cnt < lim)
		begin
			@(posedge ref_clk);
			cnt = cnt + 1;
		end
	endtask

	initial
	begin
		#300000;
		err_total = err_total + 1;
		tally_and_finish;
	end

	initial
	begin
		err_total = 0;
		n_compared = 0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(8'h30, 32'h000000FF);
		for (i = 0; i < 9; i = i + 1)
		begin
			rd(ZADDR[i], d);
			check(d, 32'h00000000);
		end
		wr(`TMR_ADDR_CTRL2, 32'h000000C8);
		wr(`TMR_ADDR_CTRL1, 32'h0000001D);
		repeat (3) @(posedge ref_clk);
		check({en2, en1, pin2, pin1, irq}, 5'b11110);
		wr(`TMR_ADDR_CTRL2, 32'h00000084);
		wr(`TMR_ADDR_CTRL1, 32'h00000050);
		wait_sig(1'b1, 1'b1, 600, n);
		repeat (520) @(posedge ref_clk);
		check({irq, pin2, en2}, 3'b110);
		wr(`TMR_ADDR_CTRL1, 32'h00000006);
		for (i = 0; i < 4; i = i + 1)
		begin
			r = ROWS[i];
			wr(`TMR_ADDR_CTRL2, 32'h000000A0 | (r[31:24] << 2));
			rd(`TMR_ADDR_STATUS, d);
			wr(`TMR_ADDR_CMP1, {24'h000000, r[15:8]});
			pins_u.strike(1'b0);
			wait_sig(1'b0, 1'b1, 600, n);
			wait_sig(1'b0, 1'b0, 600, n);
			check(n >= (r[7:0] - 1) * r[23:16] && n < r[7:0] * r[23:16], 1'b1);
			rd(`TMR_ADDR_STATUS, d);
			check(d[7:5], 3'b101);
			rd(`TMR_ADDR_CAP1, d);
			check(d, {24'h000000, `TMR_CAP1_PULSE});
		end
		wr(`TMR_ADDR_CTRL1, 32'h0000000B);
		repeat (4) @(posedge ref_clk);
		check(pin1, 1'b0);
		wr(`TMR_ADDR_CTRL1, 32'h0000000A);
		pins_u.strike(1'b0);
		wait_sig(1'b0, 1'b1, 60, n);
		check(n, 60);
		wr(`TMR_ADDR_CTRL1, 32'h00000084);
		wr(`TMR_ADDR_CTRL2, 32'h000000B4);
		rd(`TMR_ADDR_STATUS, d);
		wr(`TMR_ADDR_CMP1, 32'h000000FD);
		wr(`TMR_ADDR_CMP2, 32'h000000FF);
		wait_sig(1'b0, 1'b1, 600, n);
		wait_sig(1'b0, 1'b0, 600, n);
		wait_sig(1'b0, 1'b1, 600, n);
		check(n < 600, 1'b1);
		rd(`TMR_ADDR_STATUS, d);
		check({d[7:6], d[3], irq}, 4'b1001);
		wr(`TMR_ADDR_POWER, 32'h00000004);
		repeat (3) @(posedge ref_clk);
		check(irq, 1'b0);
		wr(`TMR_ADDR_POWER, 32'h00000001);
		rd(`TMR_ADDR_COUNT, c1);
		rd(`TMR_ADDR_COUNT, d);
		check(d, c1);
		pins_u.strike(1'b1);
		repeat (12) @(posedge ref_clk);
		wr(`TMR_ADDR_POWER, 32'h00000000);
		repeat (4) @(posedge ref_clk);
		rd(`TMR_ADDR_STATUS, d);
		check(d[4], 1'b1);
		rd(`TMR_ADDR_CAP2, d);
		check(d, c1);
		wr(`TMR_ADDR_POWER, 32'h00000002);
		repeat (3) @(posedge ref_clk);
		rd(`TMR_ADDR_POWER, d);
		check(d[1], 1'b0);
		wr(`TMR_ADDR_POWER, 32'h00000001);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(`TMR_ADDR_COUNT, d);
		check(d, {24'h000000, `TMR_CNT_RESET});
		tally_and_finish;
	end
endmodule
